// >>> hw/cct_regs.sv
`timescale 1ns/1ns
// What this block does
// RQ1: Rate-twentieth select wins, floor 27.5 mA
// RQ2: Rate-tenth select next, floor 27.5 mA
// RQ3: Otherwise termination field picks 32.5-92.5 mA
// RQ4: Fast current code 550 to 1250 mA
// RQ5: Trickle code 5, 10, 20, 20 mA
// RQ6: Recharge code 80 to 260 mV
// RQ7: Dead-to-fast code 2.4, 2.5, 2.6, 3.3 V
// RQ8: Weak rise code 2.7 to 3.4 V
// RQ9: Tied bit reads one, unused reads zero
module cct_regs (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire cct_pkg::cct_bus_req_t    bus_req_i,
  output logic                    [7:0] bus_rdata_o,
  output cct_pkg::cct_charge_cfg_t      charge_cfg_o
);

  localparam logic [cct_pkg::NUM_REGS-1:0][7:0] REG_ADDR = {
    cct_pkg::ADDR_VTHRESH, cct_pkg::ADDR_CURRENT, cct_pkg::ADDR_TERM};
  localparam logic [cct_pkg::NUM_REGS-1:0][7:0] REG_RESET = {
    cct_pkg::RST_VTHRESH, cct_pkg::RST_CURRENT, cct_pkg::RST_TERM};
  localparam logic [cct_pkg::NUM_REGS-1:0][7:0] REG_WMASK = {
    cct_pkg::WMASK_VTHRESH, cct_pkg::WMASK_CURRENT, cct_pkg::WMASK_TERM};
  localparam logic [cct_pkg::NUM_REGS-1:0][7:0] REG_ONES = {
    cct_pkg::ONES_VTHRESH, cct_pkg::ONES_CURRENT, cct_pkg::ONES_TERM};

  // Address decode, shared by the write and read paths
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    addr_hit = (addr == reg_addr);
  endfunction

  logic [cct_pkg::NUM_REGS-1:0][7:0] reg_q;
  logic [cct_pkg::NUM_REGS-1:0]      reg_we;
  logic [cct_pkg::NUM_REGS-1:0]      reg_sel;

  genvar gi;
  generate
    for (gi = 0; gi < cct_pkg::NUM_REGS; gi = gi + 1) begin : g_reg
      assign reg_sel[gi] = addr_hit(bus_req_i.addr, REG_ADDR[gi]);
      assign reg_we[gi]  = bus_req_i.wr & reg_sel[gi];
      cct_byte_reg #(
        .RESET (REG_RESET[gi]),
        .WMASK (REG_WMASK[gi]),
        .ONES  (REG_ONES[gi])
      ) u_reg (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .we_i    (reg_we[gi]),
        .wdata_i (bus_req_i.wdata),
        .q_o     (reg_q[gi])
      ); // [RQ9]
    end
  endgenerate

  // Read path: unmapped addresses return zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < cct_pkg::NUM_REGS; i++) begin
      if (reg_sel[i]) begin
        rd_mux = reg_q[i];
      end
    end
  end

  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  assign nxt_rdata   = bus_req_i.rd ? rd_mux : 8'h00;
  assign bus_rdata_o = rdata_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Field extraction
  logic [7:0] term_reg;
  logic [7:0] cur_reg;
  logic [7:0] vth_reg;
  assign term_reg = reg_q[0];
  assign cur_reg  = reg_q[1];
  assign vth_reg  = reg_q[2];

  logic       rate20_sel;
  logic       rate10_sel;
  logic [2:0] fast_current_code;
  logic [1:0] trickle_weak_current_code;
  logic [1:0] recharge_hysteresis_code;
  logic [1:0] dead_to_fast_threshold_code;
  logic [2:0] weak_rise_threshold_code;
  logic [1:0] termination_current_code;

  assign rate20_sel                  = cur_reg[cct_pkg::RATE20_BIT];
  assign rate10_sel                  = cur_reg[cct_pkg::RATE10_BIT];
  assign fast_current_code           = cur_reg[cct_pkg::FAST_LSB +: 3];
  assign trickle_weak_current_code   = cur_reg[cct_pkg::TRICKLE_LSB +: 2];
  assign recharge_hysteresis_code    = vth_reg[cct_pkg::RECHARGE_LSB +: 2];
  assign dead_to_fast_threshold_code = vth_reg[cct_pkg::DEAD_LSB +: 2];
  assign weak_rise_threshold_code    = vth_reg[cct_pkg::WEAK_LSB +: 3];
  assign termination_current_code    = term_reg[cct_pkg::TERM_LSB +: 2];

  // Code to unit decoders
  function automatic logic [4:0] trickle_ma(input logic [1:0] code);
    case (code)
      2'h0:    trickle_ma = cct_pkg::TRICKLE_LOW_MA;
      2'h1:    trickle_ma = cct_pkg::TRICKLE_MID_MA;
      default: trickle_ma = cct_pkg::TRICKLE_HIGH_MA;
    endcase
  endfunction

  function automatic logic [8:0] dead_cv(input logic [1:0] code);
    if (code == 2'h3) begin
      dead_cv = cct_pkg::DEAD_TOP_CV;
    end else begin
      dead_cv = cct_pkg::DEAD_BASE_CV + 9'(cct_pkg::DEAD_STEP_CV * {7'h00, code});
    end
  endfunction

  function automatic logic [10:0] floor_dma(input logic [10:0] val);
    floor_dma = (val < cct_pkg::TERM_FLOOR_DMA) ? cct_pkg::TERM_FLOOR_DMA : val;
  endfunction

  logic [10:0] fast_ma;
  logic [10:0] rate20_dma;
  logic [10:0] rate10_dma;
  logic [10:0] fixed_dma;

  assign fast_ma    = cct_pkg::FAST_BASE_MA
                    + 11'(cct_pkg::FAST_STEP_MA * {8'h00, fast_current_code}); // [RQ4]
  // Fast current in mA over 20 equals tenths of mA over 2; over 10 equals tenths as is
  assign rate20_dma = floor_dma(fast_ma >> 1); // [RQ1]
  assign rate10_dma = floor_dma(fast_ma); // [RQ2]
  assign fixed_dma  = cct_pkg::TERM_BASE_DMA
                    + 11'(cct_pkg::TERM_STEP_DMA * {9'h000, termination_current_code}); // [RQ3]

  cct_pkg::cct_charge_cfg_t nxt_cfg;
  always_comb begin
    nxt_cfg = '0;
    if (rate20_sel) begin
      nxt_cfg.term_mode        = cct_pkg::CCT_TERM_RATE20; // [RQ1]
      nxt_cfg.term_current_dma = rate20_dma;
    end else if (rate10_sel) begin
      nxt_cfg.term_mode        = cct_pkg::CCT_TERM_RATE10; // [RQ2]
      nxt_cfg.term_current_dma = rate10_dma;
    end else begin
      nxt_cfg.term_mode        = cct_pkg::CCT_TERM_FIXED; // [RQ3]
      nxt_cfg.term_current_dma = fixed_dma;
    end
    nxt_cfg.fast_ma     = fast_ma; // [RQ4]
    nxt_cfg.trickle_ma  = trickle_ma(trickle_weak_current_code); // [RQ5]
    nxt_cfg.recharge_mv = cct_pkg::RECHARGE_BASE_MV + 9'(cct_pkg::RECHARGE_STEP_MV
                        * {7'h00, recharge_hysteresis_code}); // [RQ6]
    nxt_cfg.dead_cv     = dead_cv(dead_to_fast_threshold_code); // [RQ7]
    nxt_cfg.weak_cv     = cct_pkg::WEAK_BASE_CV
                        + 9'(cct_pkg::WEAK_STEP_CV * {6'h00, weak_rise_threshold_code}); // [RQ8]
  end

  cct_pkg::cct_charge_cfg_t cfg_ff;
  assign charge_cfg_o = cfg_ff;

  // Reset value matches the decode of the register reset values
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_ff <= cct_pkg::RST_CFG;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

endmodule // cct_regs

// >>> pkg/cct_pkg.sv
package cct_pkg;

  // Register addresses on the byte-wide register port
  localparam logic [7:0] ADDR_TERM    = 8'h03;
  localparam logic [7:0] ADDR_CURRENT = 8'h04;
  localparam logic [7:0] ADDR_VTHRESH = 8'h05;
  localparam int         NUM_REGS     = 3;

  // Field positions, charge current register
  localparam int RATE20_BIT   = 7;
  localparam int RATE10_BIT   = 6;
  localparam int TIED_BIT     = 5;
  localparam int FAST_LSB     = 2;
  localparam int TRICKLE_LSB  = 0;
  // Field positions, voltage threshold register
  localparam int RECHARGE_LSB = 5;
  localparam int DEAD_LSB     = 3;
  localparam int WEAK_LSB     = 0;
  // Field position, termination current register
  localparam int TERM_LSB     = 0;

  // Reset values, writable bits and bits that always read one
  localparam logic [7:0] RST_TERM       = 8'h01;
  localparam logic [7:0] RST_CURRENT    = 8'h3E;
  localparam logic [7:0] RST_VTHRESH    = 8'h6B;
  localparam logic [7:0] WMASK_TERM     = 8'h03;
  localparam logic [7:0] WMASK_CURRENT  = 8'hDF;
  localparam logic [7:0] WMASK_VTHRESH  = 8'h7F;
  localparam logic [7:0] ONES_TERM      = 8'h00;
  localparam logic [7:0] ONES_CURRENT   = 8'h20;
  localparam logic [7:0] ONES_VTHRESH   = 8'h00;

  // Decoded units: mA, mV, 0.1 mA (dma) and 10 mV (cv)
  localparam logic [10:0] FAST_BASE_MA     = 11'h226;
  localparam logic [10:0] FAST_STEP_MA     = 11'h064;
  localparam logic [4:0]  TRICKLE_LOW_MA   = 5'h05;
  localparam logic [4:0]  TRICKLE_MID_MA   = 5'h0A;
  localparam logic [4:0]  TRICKLE_HIGH_MA  = 5'h14;
  localparam logic [8:0]  RECHARGE_BASE_MV = 9'h050;
  localparam logic [8:0]  RECHARGE_STEP_MV = 9'h03C;
  localparam logic [8:0]  DEAD_BASE_CV     = 9'h0F0;
  localparam logic [8:0]  DEAD_STEP_CV     = 9'h00A;
  localparam logic [8:0]  DEAD_TOP_CV      = 9'h14A;
  localparam logic [8:0]  WEAK_BASE_CV     = 9'h10E;
  localparam logic [8:0]  WEAK_STEP_CV     = 9'h00A;
  localparam logic [10:0] TERM_BASE_DMA    = 11'h145;
  localparam logic [10:0] TERM_STEP_DMA    = 11'h0C8;
  localparam logic [10:0] TERM_FLOOR_DMA   = 11'h113;

  typedef enum logic [1:0] {
    CCT_TERM_FIXED,
    CCT_TERM_RATE10,
    CCT_TERM_RATE20
  } cct_term_mode_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cct_bus_req_t;

  typedef struct packed {
    cct_term_mode_t term_mode;
    logic [10:0]    term_current_dma;
    logic [10:0]    fast_ma;
    logic [4:0]     trickle_ma;
    logic [8:0]     recharge_mv;
    logic [8:0]     dead_cv;
    logic [8:0]     weak_cv;
  } cct_charge_cfg_t;

  // Decode of the register reset values, held on the output during reset
  localparam cct_charge_cfg_t RST_CFG = '{
    term_mode:        CCT_TERM_FIXED,
    term_current_dma: 11'h20D,
    fast_ma:          11'h4E2,
    trickle_ma:       5'h14,
    recharge_mv:      9'h104,
    dead_cv:          9'h0FA,
    weak_cv:          9'h12C
  };

endpackage

// >>> hw/cct_byte_reg.sv
`timescale 1ns/1ns
module cct_byte_reg #(
  parameter logic [7:0] RESET = 8'h00,
  parameter logic [7:0] WMASK = 8'hFF,
  parameter logic [7:0] ONES  = 8'h00
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       we_i,
  input  wire logic [7:0] wdata_i,
  output logic      [7:0] q_o
);

  logic [7:0] q_ff;
  logic [7:0] nxt_q;

  // Read-only bits keep their value, fixed-one bits are forced
  assign nxt_q = we_i ? (((wdata_i & WMASK) | (q_ff & ~WMASK)) | ONES) : q_ff;
  assign q_o   = q_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      q_ff <= RESET | ONES;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule // cct_byte_reg

// >>> tb/cct_regs_props.sv
`timescale 1ns/1ns
module cct_regs_props (
  input wire logic                     clk_i,
  input wire logic                     rst_i,
  input wire cct_pkg::cct_bus_req_t    bus_req_i,
  input wire logic               [7:0] bus_rdata_o,
  input wire cct_pkg::cct_charge_cfg_t charge_cfg_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_wr_cur;
    bus_req_i.wr && bus_req_i.addr == cct_pkg::ADDR_CURRENT;
  endsequence
  sequence s_rd_cur;
    bus_req_i.rd && bus_req_i.addr == cct_pkg::ADDR_CURRENT;
  endsequence
  sequence s_rd_vth;
    bus_req_i.rd && bus_req_i.addr == cct_pkg::ADDR_VTHRESH;
  endsequence
  a_rate20_wins: assert property (s_wr_cur ##0 bus_req_i.wdata[7]
    |=> ##1 charge_cfg_o.term_mode == cct_pkg::CCT_TERM_RATE20) else $error("rate20 mode");
  a_rate20_value: assert property (charge_cfg_o.term_mode == cct_pkg::CCT_TERM_RATE20
    |-> charge_cfg_o.term_current_dma == (charge_cfg_o.fast_ma >> 1)) else $error("rate20 value");
  a_rate10_next: assert property (s_wr_cur ##0 bus_req_i.wdata[7:6] == 2'h1
    |=> ##1 charge_cfg_o.term_mode == cct_pkg::CCT_TERM_RATE10) else $error("rate10 mode");
  a_rate10_value: assert property (charge_cfg_o.term_mode == cct_pkg::CCT_TERM_RATE10
    |-> charge_cfg_o.term_current_dma == charge_cfg_o.fast_ma) else $error("rate10 value");
  a_fixed_term: assert property (charge_cfg_o.term_mode == cct_pkg::CCT_TERM_FIXED
    |-> charge_cfg_o.term_current_dma inside {11'h145, 11'h20D, 11'h2D5, 11'h39D})
    else $error("fixed term value");
  a_fast_step: assert property (s_wr_cur |=> ##1 charge_cfg_o.fast_ma ==
    11'h226 + 11'h064 * $past(bus_req_i.wdata[4:2], 2)) else $error("fast current");
  a_trickle_code: assert property (s_wr_cur |=> ##1 charge_cfg_o.trickle_ma ==
    ($past(bus_req_i.wdata[1], 2) ? 5'h14 : ($past(bus_req_i.wdata[0], 2) ? 5'h0A : 5'h05)))
    else $error("trickle current");
  a_recharge_set: assert property (charge_cfg_o.recharge_mv
    inside {9'h050, 9'h08C, 9'h0C8, 9'h104}) else $error("recharge value");
  a_dead_set: assert property (charge_cfg_o.dead_cv
    inside {9'h0F0, 9'h0FA, 9'h104, 9'h14A}) else $error("dead value");
  a_weak_range: assert property (charge_cfg_o.weak_cv
    inside {[9'h10E:9'h154]}) else $error("weak value");
  a_tied_one: assert property (s_rd_cur |=> bus_rdata_o[5]) else $error("tied bit");
  a_unused_zero: assert property (s_rd_vth |=> !bus_rdata_o[7]) else $error("unused bit");
endmodule // cct_regs_props
bind cct_regs cct_regs_props u_props (.clk_i(clk_i), .rst_i(rst_i), .bus_req_i(bus_req_i),
  .bus_rdata_o(bus_rdata_o), .charge_cfg_o(charge_cfg_o));

// >>> tb/cct_regs_bench.sv
`timescale 1ns/1ns
module cct_regs_bench;
  logic                     clk_i;
  logic                     rst_i;
  cct_pkg::cct_bus_req_t    req;
  logic               [7:0] rdata;
  cct_pkg::cct_charge_cfg_t cfg;
  int                       mismatches;
  int                       n_checks;
  logic               [4:0] trk [4] = '{5'h05, 5'h0A, 5'h14, 5'h14};
  logic               [8:0] dead [4] = '{9'h0F0, 9'h0FA, 9'h104, 9'h14A};
  cct_regs DUT (.clk_i(clk_i), .rst_i(rst_i), .bus_req_i(req), .bus_rdata_o(rdata),
    .charge_cfg_o(cfg));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task chk(input string n, input logic [10:0] g, input logic [10:0] e);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{w, r, a, d};
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    put(1'b1, 1'b0, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    put(1'b0, 1'b1, a, 8'h00);
    put(1'b0, 1'b0, 8'h00, 8'h00);
    @(negedge clk_i);
    chk("rdata", {3'h0, rdata}, {3'h0, e});
  endtask
  // Lets the decoded outputs catch up with the last write
  task settle;
    put(1'b0, 1'b0, 8'h00, 8'h00);
    @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task t_reset;
    rd(8'h03, 8'h01);
    rd(8'h04, 8'h3E);
    rd(8'h05, 8'h6B);
    rd(8'h07, 8'h00);
    chk("mode", 11'(cfg.term_mode), 11'h000);
    chk("term", cfg.term_current_dma, 11'h20D);
    chk("fast", cfg.fast_ma, 11'h4E2);
    chk("trickle", 11'(cfg.trickle_ma), 11'h014);
    chk("recharge", 11'(cfg.recharge_mv), 11'h104);
    chk("dead", 11'(cfg.dead_cv), 11'h0FA);
    chk("weak", 11'(cfg.weak_cv), 11'h12C);
  endtask
  task t_rate;
    wr(8'h04, 8'hC0);
    rd(8'h04, 8'hE0);
    chk("mode", 11'(cfg.term_mode), 11'h002);
    chk("term", cfg.term_current_dma, 11'h113);
    wr(8'h04, 8'h5C);
    settle;
    chk("mode", 11'(cfg.term_mode), 11'h001);
    chk("term", cfg.term_current_dma, 11'h4E2);
    wr(8'h04, 8'h9C);
    settle;
    chk("term", cfg.term_current_dma, 11'h271);
  endtask
  task t_fast;
    for (int c = 0; c < 8; c++) begin
      wr(8'h04, {3'h0, c[2:0], c[1:0]});
      settle;
      chk("fast", cfg.fast_ma, 11'(11'h226 + 11'h064 * c));
      chk("trickle", 11'(cfg.trickle_ma), 11'(trk[c % 4]));
      chk("mode", 11'(cfg.term_mode), 11'h000);
      rd(8'h04, {3'h1, c[2:0], c[1:0]});
    end
  endtask
  task t_term;
    for (int c = 0; c < 4; c++) begin
      wr(8'h03, {6'h3F, c[1:0]});
      settle;
      chk("term", cfg.term_current_dma, 11'(11'h145 + 11'h0C8 * c));
      rd(8'h03, {6'h00, c[1:0]});
    end
  endtask
  task t_volt;
    for (int c = 0; c < 8; c++) begin
      wr(8'h05, {1'b1, c[1:0], c[1:0], c[2:0]});
      settle;
      chk("recharge", 11'(cfg.recharge_mv), 11'(11'h050 + 11'h03C * c[1:0]));
      chk("dead", 11'(cfg.dead_cv), 11'(dead[c % 4]));
      chk("weak", 11'(cfg.weak_cv), 11'(11'h10E + 11'h00A * c));
      rd(8'h05, {1'b0, c[1:0], c[1:0], c[2:0]});
    end
  endtask
  // Unmapped write, then back-to-back write and read
  task t_unmapped;
    wr(8'h07, 8'hFF);
    wr(8'h04, 8'h00);
    rd(8'h04, 8'h20);
    rd(8'h07, 8'h00);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    req = '0;
    rst_i = 1'b1;
    mismatches = 0;
    n_checks = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_rate;
    t_fast;
    t_term;
    t_volt;
    t_unmapped;
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    test_done;
  end
endmodule // cct_regs_bench
